// ===== hw/udss_top.sv
// Sequencer core: switch decode, packet and command tables, command engine.
// Assumes a UART outside frames the bytes; host loads tables while idle.
//
// Functional notes
// - Address switch 1..F gives station address; zero defers to software.
// - Addresses 10..F7 only via software with address switch at zero.
// - Remote-I/O mode takes address from switch only, ignoring software.
// - Remote-I/O mode takes bit rate from format switch only.
// - Communication mode: format switch zero means software format, else preset.
// - Each packet holds an ordered list of at most 64 segments.
// - At most one address, length and checksum segment per packet.
// - Hex variable converts ASCII to hex; unconvertible gives zero.
// - ASCII variable converts hex to ASCII; unconvertible gives zero.
// - Null variable passes data unchanged.
// - Length segment is one or two bytes, hex or ASCII.
// - Checksum starts from initial value; reverse swaps its two bytes.
// - TX variables only read registers; RX may read, write or ignore.
// - Commands run in ascending order unless a branch redirects.
// - Command is send, receive, or send then receive.
// - Success action: next, jump, or end.
// - Failure action: next, jump, or abort.
// - Failed command retried up to its retry count.
// - Successful command repeated its repeat count before moving on.
// - Wait between commands is configurable, zero by default.
// - Missing reply within timeout, default 50 ms, is a timeout.
// - Several groups run in configured order.
`timescale 1ns/1ps
`include "udss_cfg.svh"
module udss_top
    import udss_pkg::*;
#(
    parameter int MS_CYCLES = `UDSS_MS_CYC
)(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire logic        modeRemote,
    input  wire logic [3:0]  stationAddressSwitch,
    input  wire logic [3:0]  formatSwitch,
    input  wire logic [7:0]  swAddress,
    input  wire logic [7:0]  swFormat,
    output logic      [7:0]  stationAddress,
    output logic             addrInvalid,
    output logic             fmtFromSoftware,
    output logic      [3:0]  presetSel,
    output logic      [7:0]  lineFormat,
    input  wire logic        cfgWe,
    input  wire logic [1:0]  cfgSel,
    input  wire logic [8:0]  cfgAddr,
    input  wire logic [27:0] cfgData,
    input  wire logic [3:0]  regRdAddr,
    output logic      [7:0]  regRdData,
    input  wire logic [1:0]  exchangeMode,
    input  wire logic        exchangeTrigger,
    input  wire logic [15:0] waitMs,
    input  wire logic [15:0] timeoutMs,
    input  wire logic [15:0] chkInit,
    input  wire logic        chkReverse,
    input  wire logic [2:0]  grpCount,
    output logic      [7:0]  txData,
    output logic             txValid,
    input  wire logic        txReady,
    input  wire logic [7:0]  rxData,
    input  wire logic        rxValid,
    output logic             busy,
    output logic      [3:0]  curCmd,
    output logic             cmdDone,
    output logic             cmdFail,
    output logic             seqEnd,
    output logic             seqAbort
);
    localparam logic [16:0] MS_LAST = 17'(MS_CYCLES - 1);

    // Reset release through two flops; first flop feeds only the second
    logic [1:0] rstPipe;
    logic       rstn;
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn) rstPipe <= 2'h0;
        else         rstPipe <= {rstPipe[0], 1'b1};
    end
    assign rstn = rstPipe[1];

    // Tables: 8 packets of 64 segments, 16 commands, 4 groups, 16 registers
    logic [15:0] segMem [0:511];
    logic [27:0] cmdMem [0:15];
    logic [3:0]  grpMem [0:3];
    logic [7:0]  regs   [0:15];
    logic        rxWe;
    logic [3:0]  rxWeIdx;
    logic [7:0]  rxWeData;

    // Host table loads
    always_ff @(posedge core_clk)
    begin
        if (ce && cfgWe)
        begin
            unique case (udss_cfgsel_e'(cfgSel))
                CS_SEG:  segMem[cfgAddr] <= cfgData[15:0];
                CS_CMD:  cmdMem[cfgAddr[3:0]] <= cfgData;
                CS_GRP:  grpMem[cfgAddr[1:0]] <= cfgData[3:0];
                default: ;
            endcase
        end
    end

    // Mapped registers; received data wins over a host write
    always_ff @(posedge core_clk)
    begin
        if (ce && rxWe)
            regs[rxWeIdx] <= rxWeData;
        else if (ce && cfgWe && cfgSel == CS_REG)
            regs[cfgAddr[3:0]] <= cfgData[7:0];
    end

    // Conversions for variable segments
    function automatic logic [7:0] asciiToHex(input logic [7:0] c);
        if (c >= `UDSS_CH_0 && c <= `UDSS_CH_9) return 8'(c - `UDSS_CH_0);
        if (c >= `UDSS_CH_UA && c <= `UDSS_CH_UF) return 8'(c - `UDSS_CH_UA + `UDSS_NIB_TEN);
        if (c >= `UDSS_CH_LA && c <= `UDSS_CH_LF) return 8'(c - `UDSS_CH_LA + `UDSS_NIB_TEN);
        return 8'h00;
    endfunction : asciiToHex

    function automatic logic [7:0] hexToAscii(input logic [7:0] v);
        if (v < `UDSS_NIB_TEN) return 8'(v + `UDSS_CH_0);
        if (v <= `UDSS_NIB_MAX) return 8'(v - `UDSS_NIB_TEN + `UDSS_CH_UA);
        return 8'h00;
    endfunction : hexToAscii

    function automatic logic [7:0] fmtConv(input logic [1:0] f, input logic [7:0] b);
        if (f == SF_HEX) return asciiToHex(b);
        if (f == SF_ASCII) return hexToAscii(b);
        return b;
    endfunction : fmtConv

    // Switch decode; software values are shut out in remote-I/O mode
    logic [7:0] next_stationAddress, next_lineFormat, next_regRdData;
    logic       next_addrInvalid, next_fmtFromSoftware;
    logic [3:0] next_presetSel;
    always_comb
    begin
        next_stationAddress  = {4'h0, stationAddressSwitch};
        next_addrInvalid     = modeRemote && stationAddressSwitch == 4'h0;
        if (!modeRemote && stationAddressSwitch == 4'h0)
        begin
            next_stationAddress = swAddress;
            next_addrInvalid    = swAddress < `UDSS_ADDR_MIN || swAddress > `UDSS_ADDR_MAX;
        end
        next_fmtFromSoftware = !modeRemote && formatSwitch == 4'h0;
        next_presetSel       = formatSwitch;
        next_lineFormat      = next_fmtFromSoftware ? swFormat : 8'h00;
        next_regRdData       = regs[regRdAddr];
    end

    // Two-entry transmit buffer so a receiver stall loses nothing
    logic [7:0] bufMem [0:1];
    logic       bufWr, bufRd, next_bufWr, next_bufRd;
    logic [1:0] bufCnt, next_bufCnt;
    logic       txPush, txPop;
    logic [7:0] lineByte;
    assign txPop   = txValid && txReady;
    assign txValid = bufCnt != 2'h0;
    assign txData  = bufMem[bufRd];
    always_comb
    begin
        next_bufWr  = bufWr ^ txPush;
        next_bufRd  = bufRd ^ txPop;
        next_bufCnt = 2'(bufCnt + {1'b0, txPush} - {1'b0, txPop});
    end
    always_ff @(posedge core_clk)
    begin
        if (ce && txPush) bufMem[bufWr] <= lineByte;
    end

    // Command engine state
    udss_state_e st, next_st;
    logic [3:0]  next_curCmd, retryLeft, next_retryLeft, repeatLeft, next_repeatLeft;
    logic [5:0]  seg, next_seg;
    logic        half, next_half, fresh, next_fresh;
    logic [15:0] sum, next_sum, msCount, next_msCount, tmoLimit, chkVal;
    logic [3:0]  seen, next_seen;
    logic [2:0]  grpPos, next_grpPos;
    logic [16:0] msCnt, next_msCnt;
    logic        msTick, next_cmdDone, next_cmdFail, next_seqEnd, next_seqAbort;
    logic [27:0] cmdW;
    logic [15:0] segE;
    logic [7:0]  val, srcByte;
    udss_class_e cls;
    udss_ctype_e ctype;
    logic        isVar, wide, twoByte, lastSeg, dup, step, segDone;
    logic        ok, fail, doAct, actFail, seqOver, mismatch;
    logic [1:0]  act;
    logic [3:0]  actGoto;

    // Millisecond time base
    assign msTick = msCnt == MS_LAST;
    assign next_msCnt = msTick ? 17'h00000 : 17'(msCnt + 17'h00001);

    // Segment decode, byte generation and sequencing
    always_comb
    begin
        cmdW     = cmdMem[curCmd];
        ctype    = udss_ctype_e'(cmdW[`UDSS_CMD_TYPE]);
        segE     = segMem[{(st == S_RX) ? cmdW[`UDSS_CMD_RXP] : cmdW[`UDSS_CMD_TXP], seg}];
        cls      = udss_class_e'(segE[`UDSS_SEG_CLS]);
        val      = segE[`UDSS_SEG_VAL];
        isVar    = segE[`UDSS_SEG_VAR];
        wide     = segE[13];
        lastSeg  = segE[`UDSS_SEG_LAST];
        twoByte  = (cls == SC_LEN && wide) || cls == SC_CHK;
        segDone  = !twoByte || half;
        dup      = cls != SC_MSG && !half && seen[cls];
        srcByte  = (cls == SC_ADDR) ? stationAddress : regs[val[3:0]];
        chkVal   = chkReverse ? {sum[7:0], sum[15:8]} : sum;
        tmoLimit = (timeoutMs == 16'h0000) ? `UDSS_TMO_DEF_MS : timeoutMs;
        unique case (cls)
            SC_LEN:
                if (segE[`UDSS_SEG_FMT] == SF_ASCII)
                    lineByte = wide ? hexToAscii({4'h0, half ? val[3:0] : val[7:4]})
                                    : hexToAscii(val);
                else
                    lineByte = (wide && !half) ? 8'h00 : val;
            SC_CHK:  lineByte = half ? chkVal[7:0] : chkVal[15:8];
            default: lineByte = isVar ? fmtConv(segE[`UDSS_SEG_FMT], srcByte) : val;
        endcase
        mismatch = 1'b0;
        if (cls == SC_LEN || cls == SC_CHK) mismatch = rxData != lineByte;
        else if (!isVar) mismatch = rxData != val;
        else if (segE[`UDSS_SEG_FUNC] == VF_READ)
            mismatch = fmtConv(segE[`UDSS_SEG_FMT], rxData) != srcByte;
        rxWeIdx  = val[3:0];
        rxWeData = fmtConv(segE[`UDSS_SEG_FMT], rxData);
        rxWe = 1'b0; txPush = 1'b0; step = 1'b0; ok = 1'b0; fail = 1'b0;
        doAct = 1'b0; actFail = 1'b0; seqOver = 1'b0; act = AC_END; actGoto = 4'h0;
        next_st = st; next_curCmd = curCmd; next_seg = seg; next_half = half;
        next_sum = sum; next_seen = seen; next_grpPos = grpPos; next_fresh = fresh;
        next_retryLeft = retryLeft; next_repeatLeft = repeatLeft;
        next_msCount = msCount;
        next_cmdDone = 1'b0; next_cmdFail = 1'b0; next_seqEnd = 1'b0; next_seqAbort = 1'b0;
        unique case (st)
            S_IDLE:
                if ((exchangeMode == XM_ONCE && exchangeTrigger) ||
                    exchangeMode == XM_ALWAYS)
                begin
                    next_grpPos = 3'h0;
                    next_curCmd = grpMem[0];
                    next_fresh  = 1'b1;
                    next_st     = S_LOAD;
                end
            S_WAIT:
                if (msCount >= waitMs) next_st = S_LOAD;
                else if (msTick) next_msCount = 16'(msCount + 16'h0001);
            S_LOAD:
            begin
                next_seg = 6'h00; next_half = 1'b0; next_seen = 4'h0;
                next_sum = chkInit;
                next_msCount = 16'h0000;
                if (fresh)
                begin
                    next_retryLeft  = cmdW[`UDSS_CMD_RETRY];
                    next_repeatLeft = cmdW[`UDSS_CMD_REPEAT];
                    next_fresh      = 1'b0;
                end
                next_st = (ctype == CT_RECV) ? S_RX : S_TX;
            end
            S_TX:
                if (dup) fail = 1'b1;
                else if (bufCnt != 2'h2)
                begin
                    txPush = 1'b1;
                    step   = 1'b1;
                end
            S_RX:
                if (msCount >= tmoLimit) fail = 1'b1;
                else
                begin
                    if (msTick) next_msCount = 16'(msCount + 16'h0001);
                    if (dup) fail = 1'b1;
                    else if (rxValid && mismatch) fail = 1'b1;
                    else if (rxValid)
                    begin
                        step = 1'b1;
                        rxWe = isVar && cls == SC_MSG &&
                               segE[`UDSS_SEG_FUNC] == VF_WRITE;
                    end
                end
        endcase
        // Walk to the next byte or segment
        if (step)
        begin
            next_half = twoByte && !half;
            if (segDone && !lastSeg) next_seg = 6'(seg + 6'h01);
            if (segDone && cls != SC_MSG) next_seen[cls] = 1'b1;
            if (cls != SC_CHK) next_sum = 16'(sum + {8'h00, (st == S_RX) ? rxData : lineByte});
            if (segDone && lastSeg)
            begin
                if (st == S_TX && ctype == CT_SENDRECV)
                begin
                    next_st = S_RX; next_seg = 6'h00; next_seen = 4'h0;
                    next_sum = chkInit; next_msCount = 16'h0000;
                end
                else ok = 1'b1;
            end
        end
        // Outcome of a command
        if (fail)
        begin
            next_cmdFail = 1'b1;
            if (retryLeft != 4'h0)
            begin
                next_retryLeft = 4'(retryLeft - 4'h1);
                next_st = S_LOAD;
            end
            else
            begin
                doAct = 1'b1; actFail = 1'b1;
                act = cmdW[`UDSS_CMD_FLACT]; actGoto = cmdW[`UDSS_CMD_FLGO];
            end
        end
        else if (ok)
        begin
            next_cmdDone = 1'b1;
            if (repeatLeft != 4'h0)
            begin
                next_repeatLeft = 4'(repeatLeft - 4'h1);
                next_st = S_WAIT; next_msCount = 16'h0000;
            end
            else
            begin
                doAct = 1'b1;
                act = cmdW[`UDSS_CMD_OKACT]; actGoto = cmdW[`UDSS_CMD_OKGO];
            end
        end
        if (doAct)
        begin
            unique case (act)
                AC_NEXT:
                    if (curCmd == 4'hF) seqOver = 1'b1;
                    else
                    begin
                        next_curCmd = 4'(curCmd + 4'h1);
                        next_fresh = 1'b1; next_st = S_WAIT; next_msCount = 16'h0000;
                    end
                AC_GOTO:
                begin
                    next_curCmd = actGoto;
                    next_fresh = 1'b1; next_st = S_WAIT; next_msCount = 16'h0000;
                end
                default: seqOver = 1'b1;      // End, abort, or an unused code
            endcase
        end
        if (seqOver)
        begin
            if (actFail)
            begin
                next_seqAbort = 1'b1; next_st = S_IDLE;
            end
            else if (3'(grpPos + 3'h1) < grpCount)
            begin
                next_grpPos = 3'(grpPos + 3'h1);
                next_curCmd = grpMem[2'(grpPos + 3'h1)];
                next_fresh = 1'b1; next_st = S_WAIT; next_msCount = 16'h0000;
            end
            else
            begin
                next_seqEnd = 1'b1; next_st = S_IDLE;
            end
        end
    end

    // All registered state except the reset pipe and the memories, frozen while ce is low
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st <= S_IDLE; curCmd <= 4'h0; seg <= 6'h00; half <= 1'b0; fresh <= 1'b0;
            sum <= 16'h0000; seen <= 4'h0; grpPos <= 3'h0; msCount <= 16'h0000;
            retryLeft <= 4'h0; repeatLeft <= 4'h0; msCnt <= 17'h00000;
            cmdDone <= 1'b0; cmdFail <= 1'b0; seqEnd <= 1'b0; seqAbort <= 1'b0;
            bufWr <= 1'b0; bufRd <= 1'b0; bufCnt <= 2'h0;
            stationAddress <= 8'h00; addrInvalid <= 1'b0; fmtFromSoftware <= 1'b0;
            presetSel <= 4'h0; lineFormat <= 8'h00; regRdData <= 8'h00;
        end
        else if (ce)
        begin
            st <= next_st; curCmd <= next_curCmd; seg <= next_seg; half <= next_half;
            fresh <= next_fresh; sum <= next_sum; seen <= next_seen; grpPos <= next_grpPos;
            msCount <= next_msCount; retryLeft <= next_retryLeft;
            repeatLeft <= next_repeatLeft; msCnt <= next_msCnt;
            cmdDone <= next_cmdDone; cmdFail <= next_cmdFail;
            seqEnd <= next_seqEnd; seqAbort <= next_seqAbort;
            bufWr <= next_bufWr; bufRd <= next_bufRd; bufCnt <= next_bufCnt;
            stationAddress <= next_stationAddress; addrInvalid <= next_addrInvalid;
            fmtFromSoftware <= next_fmtFromSoftware; presetSel <= next_presetSel;
            lineFormat <= next_lineFormat; regRdData <= next_regRdData;
        end
    end
    assign busy = st != S_IDLE;

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_addr_switch: assert property (ce && stationAddressSwitch != 4'h0 |=>
        stationAddress == {4'h0, $past(stationAddressSwitch)}) else $error("switch address");
    a_wide_addr: assert property (ce && !modeRemote && stationAddressSwitch != 4'h0
        |=> stationAddress <= 8'h0F) else $error("wide address via switch");
    a_remote_addr: assert property (ce && modeRemote |=> stationAddress[7:4] == 4'h0)
        else $error("remote address from software");
    a_remote_rate: assert property (ce && modeRemote |=> presetSel == $past(formatSwitch)
        && lineFormat == 8'h00) else $error("remote rate from software");
    a_soft_format: assert property (ce && !modeRemote && formatSwitch == 4'h0 |=>
        fmtFromSoftware && lineFormat == $past(swFormat)) else $error("software format");
    a_tx_no_write: assert property (st == S_TX |-> !rxWe) else $error("tx wrote register");
    a_retry_count: assert property (ce && fail && retryLeft != 4'h0 |=>
        st == S_LOAD && retryLeft == 4'($past(retryLeft) - 4'h1)) else $error("retry count");
    a_repeat_same: assert property (ce && ok && !fail && repeatLeft != 4'h0 |=>
        st == S_WAIT && curCmd == $past(curCmd)) else $error("repeat lost command");
    a_reload_entry: assert property (ce && st == S_LOAD && fresh |=>
        repeatLeft == $past(cmdW[`UDSS_CMD_REPEAT])) else $error("counter reload");
    a_timeout_fail: assert property (st == S_RX && msCount >= tmoLimit |-> fail)
        else $error("timeout missed");
    c_retry: cover property (ce && fail && retryLeft != 4'h0);
    c_repeat: cover property (ce && ok && repeatLeft != 4'h0);
    c_seq_end: cover property (ce && next_seqEnd);
endmodule : udss_top

// ===== hw/udss_cfg.svh
// Field positions, address limits, character codes and timing counts for the sequencer.
// Included by the sequencer core only, not by the package; definitions only.
`ifndef UDSS_CFG_SVH
`define UDSS_CFG_SVH

// Clock and millisecond time base
`define UDSS_CLK_NS      10
`define UDSS_MS_NS       1000000
`define UDSS_MS_CYC      ((`UDSS_MS_NS + `UDSS_CLK_NS - 1) / `UDSS_CLK_NS)
`define UDSS_TMO_DEF_MS  16'h0032

// Station address limits for software configuration
`define UDSS_ADDR_MIN    8'h01
`define UDSS_ADDR_MAX    8'hF7

// Segment descriptor fields
`define UDSS_SEG_VAL     7:0
`define UDSS_SEG_CLS     9:8
`define UDSS_SEG_FMT     11:10
`define UDSS_SEG_VAR     12
`define UDSS_SEG_FUNC    14:13
`define UDSS_SEG_LAST    15

// Command descriptor fields
`define UDSS_CMD_TYPE    1:0
`define UDSS_CMD_TXP     4:2
`define UDSS_CMD_RXP     7:5
`define UDSS_CMD_OKACT   9:8
`define UDSS_CMD_FLACT   11:10
`define UDSS_CMD_OKGO    15:12
`define UDSS_CMD_FLGO    19:16
`define UDSS_CMD_RETRY   23:20
`define UDSS_CMD_REPEAT  27:24

// Character codes used by the conversions
`define UDSS_CH_0        8'h30
`define UDSS_CH_9        8'h39
`define UDSS_CH_UA       8'h41
`define UDSS_CH_UF       8'h46
`define UDSS_CH_LA       8'h61
`define UDSS_CH_LF       8'h66
`define UDSS_NIB_TEN     8'h0A
`define UDSS_NIB_MAX     8'h0F

`endif

// ===== hw/udss_pkg.sv
// Types shared by the user-defined serial sequencer.
// Field positions and counts live in udss_cfg.svh.
package udss_pkg;
    typedef enum logic [1:0] {SC_MSG, SC_ADDR, SC_LEN, SC_CHK} udss_class_e;
    typedef enum logic [1:0] {SF_NULL, SF_HEX, SF_ASCII, SF_CODE} udss_fmt_e;
    typedef enum logic [1:0] {VF_READ, VF_WRITE, VF_IGNORE} udss_func_e;
    typedef enum logic [1:0] {CT_SEND, CT_RECV, CT_SENDRECV} udss_ctype_e;
    typedef enum logic [1:0] {AC_NEXT, AC_GOTO, AC_END} udss_act_e;
    typedef enum logic [1:0] {XM_NONE, XM_ONCE, XM_ALWAYS} udss_xmode_e;
    typedef enum logic [1:0] {CS_SEG, CS_CMD, CS_GRP, CS_REG} udss_cfgsel_e;
    typedef enum {S_IDLE, S_WAIT, S_LOAD, S_TX, S_RX} udss_state_e;
endpackage : udss_pkg

// ===== verif/udss_link_model.sv
// Far-side serial device: takes sent bytes with stalls, answers on request.
// Assumes the core_clk domain; the bench calls reply() at a rising edge.
`timescale 1ns/1ps
module udss_link_model (
    input  wire logic       core_clk,
    input  wire logic [7:0] txData,
    input  wire logic       txValid,
    output logic            txReady,
    output logic      [7:0] rxData,
    output logic            rxValid
);
    logic [7:0] lastByte;
    initial
    begin
        txReady = 1'b0;
        rxData  = 8'h00;
        rxValid = 1'b0;
    end
    // Ready only every other cycle, so the buffer sees a stall on any send of two or more bytes
    always @(posedge core_clk)
    begin
        if (txValid && txReady)
            lastByte <= txData;
        txReady <= ~txReady;
    end
    // One-cycle byte pulse; afterwards the line shows the inverse, not the old byte
    task automatic reply(input logic [7:0] b);
        rxData  <= b;
        rxValid <= 1'b1;
        @(posedge core_clk);
        rxData  <= ~b;
        rxValid <= 1'b0;
    endtask : reply
endmodule : udss_link_model

// ===== verif/user_defined_serial_sequencer_bench.sv
// Bench for the sequencer: switch decode, send, receive and timeout runs.
// Assumes udss_top and udss_link_model; inputs change at rising edges.
`timescale 1ns/1ps
module user_defined_serial_sequencer_bench;
    logic        core_clk = 1'b0, resetn = 1'b0, ce = 1'b1, modeRemote = 1'b0;
    logic        cfgWe = 1'b0, exchangeTrigger = 1'b0, chkReverse = 1'b0;
    logic [3:0]  stationAddressSwitch = 4'h0, formatSwitch = 4'h0, regRdAddr = 4'h0;
    logic [7:0]  swAddress = 8'h80, swFormat = 8'h3C, stationAddress, lineFormat;
    logic [1:0]  cfgSel = 2'h0, exchangeMode = 2'h1;
    logic [8:0]  cfgAddr = 9'h000;
    logic [27:0] cfgData = 28'h0000000;
    // Two ticks, so a reply three cycles in never races the free-running time base
    logic [15:0] waitMs = 16'h0000, timeoutMs = 16'h0002, chkInit = 16'h0000;
    logic [15:0] cnt = 16'h0000;
    logic [2:0]  grpCount = 3'h1;
    logic [3:0]  presetSel, curCmd;
    logic [7:0]  regRdData, txData, rxData;
    logic        addrInvalid, fmtFromSoftware, txValid, txReady, rxValid, busy;
    logic        cmdDone, cmdFail, seqEnd, seqAbort;
    int          n_mismatch = 0, total_checks = 0;
    logic [8:0]  swIn [4] = '{9'h050, 9'h003, 9'h100, 9'h172};
    logic [23:0] expSw [4] = '{24'h053C20, 24'h800003, 24'h000010, 24'h070002};
    logic [23:0] swOut;

    udss_top #(.MS_CYCLES(10)) i_udss_top (.*);
    udss_link_model i_udss_link_model (.*);
    // Switch decode outputs packed for one compare
    assign swOut = {stationAddress, lineFormat, 2'h0, fmtFromSoftware, addrInvalid, presetSel};

    always #5 core_clk = ~core_clk;
    // Pulse tallies, one nibble each: done, fail, end, abort
    always @(posedge core_clk)
        cnt <= cnt + {3'h0, cmdDone === 1'b1, 3'h0, cmdFail === 1'b1,
                      3'h0, seqEnd === 1'b1, 3'h0, seqAbort === 1'b1};

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [1:0] s, input logic [8:0] a, input logic [27:0] d);
        cfgWe   <= 1'b1;
        cfgSel  <= s;
        cfgAddr <= a;
        cfgData <= d;
        @(posedge core_clk);
        cfgWe   <= 1'b0;
        @(posedge core_clk);
    endtask : wr
    // Point group 0 at one command, start once, return without waiting for the run to finish
    task automatic run(input logic [27:0] cmd);
        wr(2'h2, 9'h000, cmd);
        exchangeTrigger <= 1'b1;
        @(posedge core_clk);
        exchangeTrigger <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask : run
    task automatic idle;
        for (int i = 0; i < 400 && busy !== 1'b0; i++)
            @(posedge core_clk);
        chk({23'h0, busy}, 24'h000000);
        // Two more edges so the tallies catch the closing pulses
        repeat (2) @(posedge core_clk);
    endtask : idle
    task automatic end_of_test;
        if (n_mismatch == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test

    // Main sequence
    initial
    begin
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        for (int i = 0; i < 4; i++)
        begin
            {modeRemote, stationAddressSwitch, formatSwitch} <= swIn[i];
            repeat (3) @(posedge core_clk);
            chk(swOut, expSw[i]);
        end
        modeRemote <= 1'b0;
        wr(2'h0, 9'h000, 28'h000005A);
        wr(2'h0, 9'h001, 28'h00080A5);
        wr(2'h0, 9'h040, 28'h0008033);
        wr(2'h1, 9'h000, 28'h0000200);
        wr(2'h1, 9'h001, 28'h0100A21);
        run(28'h0);
        idle();
        repeat (6) @(posedge core_clk);
        chk({i_udss_link_model.lastByte, cnt}, 24'hA51010);
        run(28'h1);
        i_udss_link_model.reply(8'h33);
        idle();
        chk({8'h00, cnt}, 24'h002020);
        // No reply: two timeouts, the first retried, the second aborts
        run(28'h1);
        chk({20'h0, curCmd}, 24'h000001);
        idle();
        chk({8'h00, cnt}, 24'h002221);
        // Received hex text lands in register 4; an ASCII variable sends it back twice
        wr(2'h0, 9'h080, 28'h000B404);
        wr(2'h0, 9'h0C0, 28'h0009804);
        wr(2'h1, 9'h002, 28'h0000A41);
        wr(2'h1, 9'h003, 28'h100020C);
        run(28'h2);
        i_udss_link_model.reply(8'h42);
        idle();
        regRdAddr <= 4'h4;
        repeat (2) @(posedge core_clk);
        chk({16'h0000, regRdData}, 24'h00000B);
        run(28'h3);
        idle();
        repeat (6) @(posedge core_clk);
        chk({i_udss_link_model.lastByte, cnt}, 24'h425241);
        // Continuous mode restarts on its own; stop it and let the last run finish
        wr(2'h2, 9'h000, 28'h0000000);
        exchangeMode <= 2'h2;
        repeat (16) @(posedge core_clk);
        exchangeMode <= 2'h0;
        idle();
        chk({12'h000, cnt[7:4] > 4'h5, 3'h0, cnt[11:8], cnt[3:0]}, 24'h000821);
        exchangeMode <= 2'h0;
        run(28'h1);
        chk({23'h0, busy}, 24'h000000);
        end_of_test();
    end
    // Watchdog well beyond the few hundred cycles the runs need
    initial
    begin
        #200us;
        n_mismatch++;
        end_of_test();
    end
endmodule : user_defined_serial_sequencer_bench
